// ===== rtl/lcsr_map.vh
/*
 * lcsr_map.vh - register offsets, field positions, reset values and mode codes
 * for the logic clock divider and frame reference controller.
 * Assumes: included by bare name from rtl files; definitions only.
 */
`ifndef LCSR_MAP_VH
`define LCSR_MAP_VH

// ============================================================
// register byte offsets (aligned words)
// ============================================================
`define LCSR_OFF_LCLK 8'h00
`define LCSR_OFF_SREF 8'h04
`define LCSR_OFF_SDIV 8'h08
`define LCSR_OFF_CTRL 8'h0C
`define LCSR_OFF_STAT 8'h10

// ============================================================
// logic clock register fields
// ============================================================
`define LCSR_PRE_LSB 0
`define LCSR_POST_LSB 4
`define LCSR_DIV2_LSB 16
`define LCSR_LCLK_RST 32'h0000_0010

// ============================================================
// frame reference config register fields
// ============================================================
`define LCSR_FSEL_LSB 0
`define LCSR_RSRC_LSB 4
`define LCSR_DLY_BIT 8
`define LCSR_PCNT_LSB 12
`define LCSR_SREF_RST 32'h0000_0000

// ============================================================
// frame reference divider register fields
// ============================================================
`define LCSR_SPRE_LSB 0
`define LCSR_SDIV_LSB 4
`define LCSR_SDIV_RST 32'h0000_0040

// ============================================================
// function select and request source codes
// ============================================================
`define LCSR_FS_GEN 2'h0
`define LCSR_FS_PULSE 2'h1
`define LCSR_FS_REP 2'h2
`define LCSR_FS_RETIME 2'h3
`define LCSR_SRC_PINS 2'h1

// ============================================================
// axi response codes
// ============================================================
`define LCSR_RESP_OKAY 2'h0
`define LCSR_RESP_SLVERR 2'h2

`endif

// ===== rtl/lcsr_top.v
/*
 * lcsr_top.v - logic clock divider chain (pre, post, second) and shared frame
 * reference (sref) generator with four functions, under an AXI4-Lite slave.
 * Assumes: sys_clk stands in for the high-frequency input clock; request pins
 * are synchronous to sys_clk; rst_n is asynchronous active low.
 */
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
//
// Behaviour
// R1: predivider limited to 1, 2 or 4
// R2: postdivider accepts ratios 1 to 1023
// R3: second divider 1,2,4,8 after postdivider
// R4: odd ratios give non-50 percent duty
// R5: sync realigns every logic clock divider
// R6: one generator feeds both output channels
// R7: function 0 gives continuous periodic pulses
// R8: request source gates generator; dividers keep running
// R9: host selects pins or forces request high
// R10: function 1 emits 1-16 pulses then stops
// R11: burst starts on pin rise or force
// R12: function 2 passes or reclocks request pins
// R13: function 3 samples, delays, then outputs request
// R14: sref predivider keeps main divider input legal
// R15: delay select picks delay path
// R16: burst restarts per trigger; retrigger ignored midburst
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_map.vh"

module lcsr_top #(
    parameter POST_W = 10, // postdivider ratio width
    parameter SDIV_W = 12 // sref main divider width
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sref_request_pins,
    input wire sync_in,
    output reg logic_clk_output_a,
    output reg logic_clk_output_b,
    output reg sref_output_pins,
    output reg logic_sref_output
);

// ============================================================
// registers
// ============================================================
reg [31:0] lclk_cfg_r; // pre, post, second divider ratios
reg [31:0] sref_cfg_r; // function, source, delay select, count
reg [31:0] sdiv_cfg_r; // sref pre and main divider
reg sync_sw_r; // software sync pulse
reg force_sw_r; // software force trigger pulse (request bit rise)

wire [1:0] logic_clk_predivider = lclk_cfg_r[`LCSR_PRE_LSB +: 2];
wire [POST_W-1:0] logic_clk_postdivider = lclk_cfg_r[`LCSR_POST_LSB +: POST_W];
wire [1:0] second_logic_clk_divider = lclk_cfg_r[`LCSR_DIV2_LSB +: 2];
wire [1:0] sref_function_select = sref_cfg_r[`LCSR_FSEL_LSB +: 2];
wire [1:0] sref_request_source = sref_cfg_r[`LCSR_RSRC_LSB +: 2];
wire sref_delay_path_select = sref_cfg_r[`LCSR_DLY_BIT];
wire [3:0] burst_pulse_count = sref_cfg_r[`LCSR_PCNT_LSB +: 4];
wire [1:0] sref_predivider = sdiv_cfg_r[`LCSR_SPRE_LSB +: 2];
wire [SDIV_W-1:0] sref_main_divider = sdiv_cfg_r[`LCSR_SDIV_LSB +: SDIV_W];

// ============================================================
// axi4-lite write path
// ============================================================
reg aw_hold_r; // address taken, awaiting data
reg w_hold_r; // data taken, awaiting address
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire aw_fire = s_axi_awvalid & s_axi_awready;
wire w_fire = s_axi_wvalid & s_axi_wready;
wire have_aw = aw_hold_r | aw_fire;
wire have_w = w_hold_r | w_fire;
wire [7:0] wr_addr = aw_fire ? s_axi_awaddr : aw_addr_r;
wire [31:0] wr_data = w_fire ? s_axi_wdata : w_data_r;
wire [3:0] wr_strb = w_fire ? s_axi_wstrb : w_strb_r;
wire wr_go = have_aw & have_w & ~s_axi_bvalid;
wire [1:0] new_src = wr_data[`LCSR_RSRC_LSB +: 2];

// byte-lane merge of write data into an old word
function [31:0] lcsr_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
        lcsr_merge = old_v;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                lcsr_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    end
endfunction

// write handshake, storage and side effects
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `LCSR_RESP_OKAY;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        aw_addr_r <= 8'h00;
        w_data_r <= 32'h0000_0000;
        w_strb_r <= 4'h0;
        lclk_cfg_r <= `LCSR_LCLK_RST;
        sref_cfg_r <= `LCSR_SREF_RST;
        sdiv_cfg_r <= `LCSR_SDIV_RST;
        sync_sw_r <= 1'b0;
        force_sw_r <= 1'b0;
    end else begin
        sync_sw_r <= 1'b0;
        force_sw_r <= 1'b0;
        // ready only while nothing is parked and no response stands
        s_axi_awready <= ~have_aw & ~s_axi_awready & ~s_axi_bvalid;
        s_axi_wready <= ~have_w & ~s_axi_wready & ~s_axi_bvalid;
        if (aw_fire) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (w_fire) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `LCSR_RESP_OKAY;
            if (wr_addr[7:2] == `LCSR_OFF_LCLK >> 2) begin
                lclk_cfg_r <= lcsr_merge(lclk_cfg_r, wr_data, wr_strb);
            end else if (wr_addr[7:2] == `LCSR_OFF_SREF >> 2) begin
                sref_cfg_r <= lcsr_merge(sref_cfg_r, wr_data, wr_strb);
                // force: upper source bit going 0 to 1
                if (wr_strb[0] && new_src[1] && !sref_request_source[1]) begin
                    force_sw_r <= 1'b1; // R9 R11
                end
            end else if (wr_addr[7:2] == `LCSR_OFF_SDIV >> 2) begin
                sdiv_cfg_r <= lcsr_merge(sdiv_cfg_r, wr_data, wr_strb);
            end else if (wr_addr[7:2] == `LCSR_OFF_CTRL >> 2) begin
                sync_sw_r <= wr_strb[0] & wr_data[0];
            end else if (wr_addr[7:2] != `LCSR_OFF_STAT >> 2) begin
                s_axi_bresp <= `LCSR_RESP_SLVERR; // unmapped
            end
        end
    end
end

// ============================================================
// axi4-lite read path
// ============================================================
reg [3:0] burst_left_r; // pulses still to send after the current one
reg burst_busy_r;
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LCSR_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `LCSR_RESP_OKAY;
            if (s_axi_araddr[7:2] == `LCSR_OFF_LCLK >> 2) begin
                s_axi_rdata <= lclk_cfg_r;
            end else if (s_axi_araddr[7:2] == `LCSR_OFF_SREF >> 2) begin
                s_axi_rdata <= sref_cfg_r;
            end else if (s_axi_araddr[7:2] == `LCSR_OFF_SDIV >> 2) begin
                s_axi_rdata <= sdiv_cfg_r;
            end else if (s_axi_araddr[7:2] == `LCSR_OFF_CTRL >> 2) begin
                s_axi_rdata <= 32'h0000_0000; // sync is self-clearing
            end else if (s_axi_araddr[7:2] == `LCSR_OFF_STAT >> 2) begin
                // live state: busy, remaining pulses, outputs
                s_axi_rdata <= {24'h00_0000, burst_left_r, burst_busy_r,
                    sref_output_pins, logic_clk_output_b, logic_clk_output_a};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `LCSR_RESP_SLVERR;
            end
        end
    end
end

// ============================================================
// logic clock divider chain
// ============================================================
reg sync_d_r; // previous sync_in for edge
wire sync_now = sync_sw_r | (sync_in & ~sync_d_r);
reg [1:0] pre_cnt_r;
reg [POST_W-1:0] post_cnt_r;
reg [2:0] div2_cnt_r;
// predivider tick: code 0 -> /1, 1 -> /2, else /4
wire [1:0] pre_max = (logic_clk_predivider == 2'h0) ? 2'h0 :
    (logic_clk_predivider == 2'h1) ? 2'h1 : 2'h3; // R1
wire pre_tick = (pre_cnt_r == pre_max);
// ratio 0 and 1 both taken as bypass
wire post_byp = (logic_clk_postdivider <= {{(POST_W-1){1'b0}}, 1'b1});
wire [POST_W-1:0] post_last = logic_clk_postdivider - {{(POST_W-1){1'b0}}, 1'b1};
wire post_tick = pre_tick & (post_byp | (post_cnt_r == post_last));
// high for floor(n/2) counts: odd ratios run short of half duty
wire post_high = (post_cnt_r < (logic_clk_postdivider >> 1)); // R4
wire [2:0] div2_mask = (3'h1 << second_logic_clk_divider) - 3'h1;

// pre, post and second divider counters; sync clears them all together
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        sync_d_r <= 1'b0;
        pre_cnt_r <= 2'h0;
        post_cnt_r <= {POST_W{1'b0}};
        div2_cnt_r <= 3'h0;
        logic_clk_output_a <= 1'b0;
        logic_clk_output_b <= 1'b0;
    end else begin
        sync_d_r <= sync_in;
        if (sync_now) begin
            pre_cnt_r <= 2'h0; // R5
            post_cnt_r <= {POST_W{1'b0}}; // R5
            div2_cnt_r <= 3'h0; // R5
            logic_clk_output_a <= 1'b0;
            logic_clk_output_b <= 1'b0;
        end else begin
            pre_cnt_r <= pre_tick ? 2'h0 : pre_cnt_r + 2'h1;
            if (pre_tick) begin
                if (post_byp) begin
                    // bypass: toggle per predivided tick gives 50 percent
                    logic_clk_output_a <= ~logic_clk_output_a; // R2 R4
                end else begin
                    post_cnt_r <= (post_cnt_r == post_last) ? {POST_W{1'b0}} :
                        post_cnt_r + {{(POST_W-1){1'b0}}, 1'b1}; // R2
                    logic_clk_output_a <= post_high;
                end
            end
            if (post_tick) begin
                div2_cnt_r <= (div2_cnt_r + 3'h1) & div2_mask; // R3
            end
            // second output: bypass copies a, else msb of counter
            if (second_logic_clk_divider == 2'h0) begin
                logic_clk_output_b <= !pre_tick ? logic_clk_output_a :
                    post_byp ? ~logic_clk_output_a : post_high; // R3
            end else begin
                logic_clk_output_b <= div2_cnt_r[second_logic_clk_divider - 2'h1]; // R3
            end
        end
    end
end

// ============================================================
// shared sref generator
// ============================================================
reg [1:0] spre_cnt_r;
reg [SDIV_W-1:0] sdiv_cnt_r;
reg gen_r; // free-running generator level
reg req_d_r; // previous request pin for edge
reg req_samp_r; // retimed request sample
reg dly_r; // delay path stage
wire [1:0] spre_max = (sref_predivider == 2'h0) ? 2'h0 :
    (sref_predivider == 2'h1) ? 2'h1 : 2'h3; // R14
wire spre_tick = (spre_cnt_r == spre_max);
wire [SDIV_W-1:0] sdiv_last = (sref_main_divider < 2) ? {{(SDIV_W-1){1'b0}}, 1'b1} :
    sref_main_divider - {{(SDIV_W-1){1'b0}}, 1'b1};
wire sdiv_wrap = spre_tick & (sdiv_cnt_r == sdiv_last);
wire pin_rise = sref_request_pins & ~req_d_r;
wire trig = ((sref_request_source == `LCSR_SRC_PINS) & pin_rise) | force_sw_r; // R11
// gate: pins level or forced-high upper bit
wire gate_on = (sref_request_source == `LCSR_SRC_PINS) ? sref_request_pins :
    sref_request_source[1]; // R8 R9
reg sref_nxt;

// generator counters never stop, so gating keeps phase
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        spre_cnt_r <= 2'h0;
        sdiv_cnt_r <= {SDIV_W{1'b0}};
        gen_r <= 1'b0;
        req_d_r <= 1'b0;
        req_samp_r <= 1'b0;
        dly_r <= 1'b0;
        burst_left_r <= 4'h0;
        burst_busy_r <= 1'b0;
    end else begin
        req_d_r <= sref_request_pins;
        req_samp_r <= sref_request_pins; // R13
        spre_cnt_r <= (spre_tick | sync_now) ? 2'h0 : spre_cnt_r + 2'h1;
        if (sync_now) begin
            sdiv_cnt_r <= {SDIV_W{1'b0}};
            gen_r <= 1'b0;
        end else if (spre_tick) begin
            sdiv_cnt_r <= (sdiv_cnt_r == sdiv_last) ? {SDIV_W{1'b0}} :
                sdiv_cnt_r + {{(SDIV_W-1){1'b0}}, 1'b1}; // R8
            if (sdiv_cnt_r == sdiv_last) begin
                gen_r <= ~gen_r; // R7
            end
        end
        // pulser: count 0 means 16 pulses
        if (sref_function_select != `LCSR_FS_PULSE) begin
            burst_busy_r <= 1'b0;
            burst_left_r <= 4'h0;
        end else if (!burst_busy_r) begin
            if (trig) begin
                burst_busy_r <= 1'b1; // R16
                burst_left_r <= burst_pulse_count - 4'h1; // R10 R16
            end
        end else if (gen_r && sdiv_wrap) begin
            // end of a pulse; retriggers ignored until done
            if (burst_left_r == 4'h0) begin
                burst_busy_r <= 1'b0; // R10
            end else begin
                burst_left_r <= burst_left_r - 4'h1;
            end
        end
        dly_r <= sref_nxt;
    end
end

// output select per function
always @* begin
    case (sref_function_select)
        `LCSR_FS_GEN: sref_nxt = gen_r & gate_on; // R7 R8
        `LCSR_FS_PULSE: sref_nxt = gen_r & burst_busy_r; // R10
        `LCSR_FS_REP: sref_nxt = sref_request_pins; // R12
        default: sref_nxt = req_samp_r; // R13
    endcase
end

// both channels fed from one source, reclocked at their outputs
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        sref_output_pins <= 1'b0;
        logic_sref_output <= 1'b0;
    end else begin
        sref_output_pins <= sref_delay_path_select ? dly_r : sref_nxt; // R6 R12 R15
        logic_sref_output <= sref_delay_path_select ? dly_r : sref_nxt; // R6
    end
end

endmodule
`default_nettype wire

// ===== verif/lcsr_properties.sv
/* handshake and shared reference checks for the clock divider block.
   assumes: bound to lcsr_top, sees its ports only */
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_map.vh"
module lcsr_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sref_output_pins,
    input wire logic logic_sref_output
);
    // ==========================================
    // clocking and handshake steps
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // address and data taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========================================
    // assertions
    a_sref_shared: assert property (logic_sref_output == sref_output_pins)
        else $error("logic channel reference differs");
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_wr_refused: assert property (s_wr_take ##0 (s_axi_awaddr >= 8'h14)
        |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `LCSR_RESP_SLVERR))
        else $error("unmapped write not refused");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_no_new_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted before response");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_refused: assert property (s_rd_take ##0 (s_axi_araddr >= 8'h14)
        |=> s_axi_rdata == 32'h0 && s_axi_rresp == `LCSR_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind lcsr_top lcsr_properties i_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sref_output_pins(sref_output_pins),
    .logic_sref_output(logic_sref_output));
`default_nettype wire

// ===== verif/lcsr_far_end.sv
/* far side: requester driving the request pin and receivers counting edges.
   assumes: block outputs are registered levels on sys_clk */
`timescale 1ns/1ps
`default_nettype none
module lcsr_far_end (
    input wire logic sys_clk,
    input wire logic req_cmd,
    input wire logic clr,
    input wire logic clk_a,
    input wire logic clk_b,
    input wire logic sref,
    output logic req_pin,
    output logic [15:0] cnt_a,
    output logic [15:0] cnt_b,
    output logic [15:0] cnt_s,
    output logic [15:0] hi_a
);
    // ==========================================
    // requester and receivers
    logic pa, pb, ps; // last levels, for edge detection
    // pin moves just after the edge, as a real requester would
    always @(posedge sys_clk) req_pin <= req_cmd;
    // edge counts restart on clr
    always @(posedge sys_clk) begin
        pa <= clk_a;
        pb <= clk_b;
        ps <= sref;
        cnt_a <= clr ? 16'h0 : cnt_a + 16'(clk_a && !pa);
        cnt_b <= clr ? 16'h0 : cnt_b + 16'(clk_b && !pb);
        cnt_s <= clr ? 16'h0 : cnt_s + 16'(sref && !ps);
        hi_a <= clr ? 16'h0 : hi_a + 16'(clk_a);
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/* bench for the clock divider block: bus tasks, divider, sync and reference tests.
   assumes: far-end model lcsr_far_end and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_map.vh"
module tb_top;
    // ==========================================
    // signals
    logic sys_clk = 1'b0, rst_n = 1'b0, req_cmd = 1'b0, clr = 1'b0, sync_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, req_pin, clk_a, clk_b, sref, lsref;
    logic [1:0] bresp, rresp;
    logic [15:0] cnt_a, cnt_b, cnt_s, hi_a;
    int num_errors = 0, n_compared = 0, lat[4], l1, l2;
    always #4 sys_clk = ~sys_clk; // 125 MHz
    lcsr_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sref_request_pins(req_pin), .sync_in(sync_in),
        .logic_clk_output_a(clk_a), .logic_clk_output_b(clk_b),
        .sref_output_pins(sref), .logic_sref_output(lsref));
    lcsr_far_end i_far (.sys_clk(sys_clk), .req_cmd(req_cmd), .clr(clr), .clk_a(clk_a),
        .clk_b(clk_b), .sref(sref), .req_pin(req_pin), .cnt_a(cnt_a), .cnt_b(cnt_b),
        .cnt_s(cnt_s), .hi_a(hi_a));
    // ==========================================
    // compare and bus tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    // window counts may miss one edge at either end
    task rng(input logic [15:0] v, input int lo, input int hi);
        chk({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    // address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge sys_clk);
            if (awvalid && awready === 1'b1) begin
                ga = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                gw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        chk(bresp, er);
    endtask
    task wok(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, `LCSR_RESP_OKAY);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    // clear the far-end counters, then let n cycles pass
    task meas(input int n);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    // cycles from request rise to reference rise; then the fall must follow
    task req_lat(output int l);
        req_cmd <= 1'b1;
        l = 0;
        do begin
            @(posedge sys_clk);
            l++;
        end while (sref !== 1'b1 && l < 40);
        req_cmd <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk({31'h0, sref}, 32'h0);
    endtask
    // sync by pin or register, then cycles to the next rise of output a
    task sync_lat(input logic by_reg, output int l);
        if (by_reg) wok(`LCSR_OFF_CTRL, 32'h1);
        else begin
            sync_in <= 1'b1;
            @(posedge sys_clk);
            sync_in <= 1'b0;
        end
        for (l = 0; clk_a !== 1'b0 && l < 40; l++) @(posedge sys_clk);
        while (clk_a !== 1'b1 && l < 40) begin
            @(posedge sys_clk);
            l++;
        end
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(`LCSR_OFF_LCLK, `LCSR_LCLK_RST, `LCSR_RESP_OKAY);
        rd(`LCSR_OFF_SREF, `LCSR_SREF_RST, `LCSR_RESP_OKAY);
        rd(`LCSR_OFF_SDIV, `LCSR_SDIV_RST, `LCSR_RESP_OKAY);
        rd(8'h14, 32'h0, `LCSR_RESP_SLVERR);
        wr(8'h14, 32'hFFFF_FFFF, `LCSR_RESP_SLVERR);
        wok(`LCSR_OFF_STAT, 32'hFFFF_FFFF);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            int e;
            e = 200 >> (k == 3 ? 2 : k);
            wok(`LCSR_OFF_LCLK, 32'((k << 16) | 32'h40 | k));
            meas(800);
            rng(cnt_a, e - 2, e + 2);
            rng(cnt_b, (e >> k) - 2, (e >> k) + 2);
        end
        wok(`LCSR_OFF_LCLK, 32'h30);
        meas(600);
        chk({31'h0, hi_a >= 16'd290 && hi_a <= 16'd310}, 32'h0);
        wok(`LCSR_OFF_LCLK, 32'h40);
        meas(600);
        rng(hi_a, 295, 305);
        $display("test dividers done");
        wok(`LCSR_OFF_LCLK, 32'h50);
        for (int s = 0; s < 2; s++) begin
            sync_lat(s[0], l1);
            repeat (3 + s) @(posedge sys_clk);
            sync_lat(s[0], l2);
            chk(l1 < 40, 1);
            chk(l2, l1);
        end
        $display("test sync done");
        wok(`LCSR_OFF_SDIV, 32'h80);
        wok(`LCSR_OFF_SREF, 32'h0);
        meas(200);
        chk(cnt_s, 32'h0);
        wok(`LCSR_OFF_SREF, 32'h10);
        meas(200);
        chk(cnt_s, 32'h0);
        req_cmd <= 1'b1;
        meas(400);
        rng(cnt_s, 24, 26);
        req_cmd <= 1'b0;
        wok(`LCSR_OFF_SREF, 32'h20);
        meas(400);
        rng(cnt_s, 24, 26);
        $display("test generator done");
        wok(`LCSR_OFF_SREF, 32'h3011);
        meas(2);
        req_cmd <= 1'b1;
        repeat (6) @(posedge sys_clk);
        req_cmd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        req_cmd <= 1'b1;
        repeat (60) @(posedge sys_clk);
        chk(cnt_s, 32'h3);
        req_cmd <= 1'b0;
        repeat (4) @(posedge sys_clk);
        req_cmd <= 1'b1;
        repeat (60) @(posedge sys_clk);
        chk(cnt_s, 32'h6);
        wok(`LCSR_OFF_SREF, 32'h1);
        req_cmd <= 1'b0;
        meas(2);
        wok(`LCSR_OFF_SREF, 32'h21);
        repeat (300) @(posedge sys_clk);
        chk(cnt_s, 32'h10);
        $display("test pulser done");
        for (int m = 0; m < 4; m++) begin
            wok(`LCSR_OFF_SREF, 32'(32'h12 + (m >> 1) + ((m & 1) << 8)));
            req_lat(lat[m]);
        end
        chk(lat[0] < 10, 1);
        chk(lat[1], lat[0] + 1);
        chk(lat[3], lat[2] + 1);
        chk(lat[2] >= lat[0], 1);
        $display("test repeater done");
        print_verdict();
    end
    // hang guard: tests need well under 10000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
